// ### rtl/pogpm_port.sv
/*
 * Four-pin general-purpose port (pins 7, 6, 4, 3) with pin function
 * select, pull-up control, the shared second mode register, an edge
 * detector on pin 7 and a switchable noise filter on pin 3.
 * Assumes an AXI4-Lite master with one write and one read in flight
 * at most, and pin inputs already synchronous to clk.
 */
// Functional notes
// - data read: output value or live pin
// - direction bit 1 drives, 0 inputs
// - direction and data apply only in I/O use
// - direction register write-only, reads all ones
// - pull-up only when input and enabled
// - 8-bit registers, bits 7,6,4,3 mapped
// - mode bit 7 picks I/O or interrupt/event
// - mode bit 4 picks I/O or interrupt/trigger
// - mode bit 3 picks I/O or capture input
// - pin 7 edge: rising or falling selectable
// - mode bits 6 and 1 read one, fixed
// - second mode register resets to D8
// - second mode bit 2 selects watchdog clock
// - direction chosen per bit
// - second mode bit 1 enables capture filter
// - pull-ups off after reset
module pogpm_port #(
	parameter int FILT_LEN = pogpm_pkg::FILT_LEN_DEF
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [17:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [17:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe,
	output logic [7:0] pin_pullup_en,
	output logic ext_int_three_level,
	output logic pin7_edge_event,
	output logic ext_int_four_level,
	output logic converter_trigger_level,
	output logic capture_input_level,
	output logic watchdog_clock_select
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	pogpm_pkg::pogpm_wr_state_t wr_st_r;
	pogpm_pkg::pogpm_wr_state_t wr_nxt;
	logic aw_hs;
	logic w_hs;
	logic ar_hs;
	logic [17:0] awaddr_r;
	logic [7:0] wbyte_r;
	logic wlane_r;
	logic wr_go_r;
	logic [7:0] func_sel_r;
	logic [7:0] mode2_r;
	logic [7:0] out_data_r;
	logic [7:0] pullup_r;
	logic [7:0] dir_r;
	logic edge_rise_r;
	logic [7:0] eff_dir;
	logic [7:0] gpio_en;
	logic pin7_fn_level;
	logic filt_level;
	logic filt_on_bit;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// word address to register selector; unused low bits are ignored
	function automatic pogpm_pkg::pogpm_sel_t reg_sel(
		input logic [17:0] addr);
		logic [17:0] a;
		a = {addr[17:2], 2'h0};
		case (a)
			pogpm_pkg::ADDR_FUNC_SEL: reg_sel = pogpm_pkg::POGPM_SEL_FUNC;
			pogpm_pkg::ADDR_MODE_TWO: reg_sel = pogpm_pkg::POGPM_SEL_MODE2;
			pogpm_pkg::ADDR_OUT_DATA: reg_sel = pogpm_pkg::POGPM_SEL_DATA;
			pogpm_pkg::ADDR_PULLUP: reg_sel = pogpm_pkg::POGPM_SEL_PULL;
			pogpm_pkg::ADDR_DIR: reg_sel = pogpm_pkg::POGPM_SEL_DIR;
			pogpm_pkg::ADDR_EDGE_CTRL: reg_sel = pogpm_pkg::POGPM_SEL_EDGE;
			default: reg_sel = pogpm_pkg::POGPM_SEL_NONE;
		endcase
	endfunction

	// keep only the mapped pin positions of a byte
	function automatic logic [7:0] pin_bits(input logic [7:0] v);
		pin_bits = v & pogpm_pkg::PIN_MASK;
	endfunction

	// ----------------------------------------------------------------
	// handshakes
	// ----------------------------------------------------------------
	assign aw_hs = s_axi_awvalid & s_axi_awready;
	assign w_hs = s_axi_wvalid & s_axi_wready;
	assign ar_hs = s_axi_arvalid & s_axi_arready;

	// ----------------------------------------------------------------
	// write channel state
	// ----------------------------------------------------------------
	// address and data are taken in either order; response follows both
	always_comb begin
		wr_nxt = wr_st_r;
		case (wr_st_r)
			pogpm_pkg::POGPM_W_IDLE: begin
				if (aw_hs && w_hs)
					wr_nxt = pogpm_pkg::POGPM_W_RESP;
				else if (aw_hs)
					wr_nxt = pogpm_pkg::POGPM_W_ADDR;
				else if (w_hs)
					wr_nxt = pogpm_pkg::POGPM_W_DATA;
			end
			pogpm_pkg::POGPM_W_ADDR: begin
				if (w_hs)
					wr_nxt = pogpm_pkg::POGPM_W_RESP;
			end
			pogpm_pkg::POGPM_W_DATA: begin
				if (aw_hs)
					wr_nxt = pogpm_pkg::POGPM_W_RESP;
			end
			pogpm_pkg::POGPM_W_RESP: begin
				if (s_axi_bvalid && s_axi_bready)
					wr_nxt = pogpm_pkg::POGPM_W_IDLE;
			end
			default: wr_nxt = pogpm_pkg::POGPM_W_IDLE;
		endcase
	end

	// state, readies and the one-cycle commit strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_st_r <= pogpm_pkg::POGPM_W_IDLE;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			wr_go_r <= 1'b0;
		end else begin
			wr_st_r <= wr_nxt;
			s_axi_awready <= (wr_nxt == pogpm_pkg::POGPM_W_IDLE) ||
				(wr_nxt == pogpm_pkg::POGPM_W_DATA);
			s_axi_wready <= (wr_nxt == pogpm_pkg::POGPM_W_IDLE) ||
				(wr_nxt == pogpm_pkg::POGPM_W_ADDR);
			wr_go_r <= (wr_nxt == pogpm_pkg::POGPM_W_RESP) &&
				(wr_st_r != pogpm_pkg::POGPM_W_RESP);
		end
	end

	// capture address and low data byte as each arrives
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			awaddr_r <= 18'h00000;
			wbyte_r <= 8'h00;
			wlane_r <= 1'b0;
		end else begin
			if (aw_hs)
				awaddr_r <= s_axi_awaddr;
			if (w_hs) begin
				wbyte_r <= s_axi_wdata[7:0];
				wlane_r <= s_axi_wstrb[0];
			end
		end
	end

	// response rises with the register update, so a read after bvalid
	// always sees the new value
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= pogpm_pkg::RESP_OKAY;
		end else if (wr_go_r) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (reg_sel(awaddr_r) == pogpm_pkg::POGPM_SEL_NONE)
				? pogpm_pkg::RESP_SLVERR : pogpm_pkg::RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	// clear on reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_data_r <= pogpm_pkg::PORT_RESET;
			dir_r <= pogpm_pkg::PORT_RESET;
			pullup_r <= pogpm_pkg::PORT_RESET;
		end else if (wr_go_r && wlane_r) begin
			case (reg_sel(awaddr_r))
				pogpm_pkg::POGPM_SEL_DATA: out_data_r <= pin_bits(wbyte_r);
				pogpm_pkg::POGPM_SEL_DIR: dir_r <= pin_bits(wbyte_r);
				pogpm_pkg::POGPM_SEL_PULL: pullup_r <= pin_bits(wbyte_r);
				default: ;
			endcase
		end
	end

	// function select keeps only its three switch bits; the reserved
	// write-zero bits are dropped, so a stray one does no harm
	// reserved bits discarded
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			func_sel_r <= pogpm_pkg::PORT_RESET;
		else if (wr_go_r && wlane_r &&
			reg_sel(awaddr_r) == pogpm_pkg::POGPM_SEL_FUNC)
			func_sel_r <= wbyte_r & pogpm_pkg::FUNC_WR_MASK;
	end

	// second mode register: fixed ones are forced back on every write
	// resets to D8
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			mode2_r <= pogpm_pkg::MODE2_RESET;
		else if (wr_go_r && wlane_r &&
			reg_sel(awaddr_r) == pogpm_pkg::POGPM_SEL_MODE2)
			mode2_r <= (wbyte_r & pogpm_pkg::MODE2_WR_MASK) |
				(pogpm_pkg::MODE2_RESET & ~pogpm_pkg::MODE2_WR_MASK);
	end

	// pin 7 edge polarity; 0 is falling, the idle-high default
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			edge_rise_r <= 1'b0;
		else if (wr_go_r && wlane_r &&
			reg_sel(awaddr_r) == pogpm_pkg::POGPM_SEL_EDGE)
			edge_rise_r <= wbyte_r[pogpm_pkg::BIT_EDGE_RISE];
	end

	// ----------------------------------------------------------------
	// read channel
	// ----------------------------------------------------------------
	// one read at a time: arready drops until the data is taken
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= pogpm_pkg::RESP_OKAY;
		end else if (ar_hs) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= pogpm_pkg::RESP_OKAY;
			case (reg_sel(s_axi_araddr))
				pogpm_pkg::POGPM_SEL_DATA:
					s_axi_rdata <= {24'h000000, pin_bits(
						(dir_r & out_data_r) | (~dir_r & pin_in))};
				pogpm_pkg::POGPM_SEL_DIR:
					s_axi_rdata <= {24'h000000, pogpm_pkg::DIR_READ_VAL};
				pogpm_pkg::POGPM_SEL_PULL:
					s_axi_rdata <= {24'h000000, pullup_r};
				pogpm_pkg::POGPM_SEL_FUNC:
					s_axi_rdata <= {24'h000000,
						func_sel_r | pogpm_pkg::FUNC_RD_ONES};
				pogpm_pkg::POGPM_SEL_MODE2:
					s_axi_rdata <= {24'h000000, mode2_r};
				pogpm_pkg::POGPM_SEL_EDGE:
					s_axi_rdata <= {31'h00000000, edge_rise_r};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= pogpm_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// pin function decode
	// ----------------------------------------------------------------
	// a pin in its alternate function is always an input, so the
	// direction and data bits are ignored at its pad but kept for later
	// gpio use; the data register read still follows them
	assign gpio_en = ~func_sel_r;
	assign eff_dir = pin_bits(dir_r & gpio_en);
	assign filt_on_bit = mode2_r[pogpm_pkg::BIT_FILT_ON];

	// pad controls, registered so the pins never see decode glitches
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_oe <= 8'h00;
			pin_out <= 8'h00;
			pin_pullup_en <= 8'h00;
		end else begin
			pin_oe <= eff_dir;
			pin_out <= out_data_r & eff_dir;
			pin_pullup_en <= pin_bits(pullup_r & ~eff_dir);
		end
	end

	// alternate inputs idle high while their pin is in gpio use
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_int_three_level <= 1'b1;
			ext_int_four_level <= 1'b1;
			converter_trigger_level <= 1'b1;
			capture_input_level <= 1'b1;
			watchdog_clock_select <= 1'b0;
		end else begin
			ext_int_three_level <= pin7_fn_level;
			ext_int_four_level <= func_sel_r[pogpm_pkg::BIT_P4]
				? pin_in[pogpm_pkg::BIT_P4] : 1'b1;
			converter_trigger_level <= func_sel_r[pogpm_pkg::BIT_P4]
				? pin_in[pogpm_pkg::BIT_P4] : 1'b1;
			capture_input_level <= filt_on_bit ? filt_level
				: (func_sel_r[pogpm_pkg::BIT_P3]
				? pin_in[pogpm_pkg::BIT_P3] : 1'b1);
			watchdog_clock_select <= mode2_r[pogpm_pkg::BIT_WDOG_CLK];
		end
	end

	assign pin7_fn_level = func_sel_r[pogpm_pkg::BIT_P7]
		? pin_in[pogpm_pkg::BIT_P7] : 1'b1;

	// ----------------------------------------------------------------
	// event and filter helpers
	// ----------------------------------------------------------------
	// selectable edge
	pogpm_edge_detect u_edge (
		.clk(clk),
		.rst_n(rst_n),
		.sig_in(pin7_fn_level),
		.rise_sel(edge_rise_r),
		.event_pulse(pin7_edge_event)
	);

	pogpm_noise_filter #(
		.FILT_LEN(FILT_LEN)
	) u_filt (
		.clk(clk),
		.rst_n(rst_n),
		.sig_in(func_sel_r[pogpm_pkg::BIT_P3]
			? pin_in[pogpm_pkg::BIT_P3] : 1'b1),
		.filt_out(filt_level)
	);
endmodule

// ### rtl/pogpm_pkg.sv
/*
 * Shared constants for the four-pin port block: register indices and
 * byte addresses, field masks and positions, reset values, bus answers
 * and the write-channel state encoding.
 * Assumes a 32-bit AXI4-Lite register bus where each register takes
 * one aligned word at four times its index.
 */
package pogpm_pkg;

	// ----------------------------------------------------------------
	// bus geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W = 18;
	localparam int DATA_W = 32;

	// ----------------------------------------------------------------
	// register indices and byte addresses
	// ----------------------------------------------------------------
	localparam logic [15:0] IDX_FUNC_SEL = 16'hFFC8;
	localparam logic [15:0] IDX_MODE_TWO = 16'hFFC9;
	localparam logic [15:0] IDX_OUT_DATA = 16'hFFD4;
	localparam logic [15:0] IDX_PULLUP = 16'hFFE0;
	localparam logic [15:0] IDX_DIR = 16'hFFE4;
	localparam logic [15:0] IDX_EDGE_CTRL = 16'hFFCC;
	localparam logic [17:0] ADDR_FUNC_SEL = {IDX_FUNC_SEL, 2'h0};
	localparam logic [17:0] ADDR_MODE_TWO = {IDX_MODE_TWO, 2'h0};
	localparam logic [17:0] ADDR_OUT_DATA = {IDX_OUT_DATA, 2'h0};
	localparam logic [17:0] ADDR_PULLUP = {IDX_PULLUP, 2'h0};
	localparam logic [17:0] ADDR_DIR = {IDX_DIR, 2'h0};
	localparam logic [17:0] ADDR_EDGE_CTRL = {IDX_EDGE_CTRL, 2'h0};

	// ----------------------------------------------------------------
	// field masks, positions and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] PIN_MASK = 8'hD8;
	localparam logic [7:0] FUNC_WR_MASK = 8'h98;
	localparam logic [7:0] FUNC_RD_ONES = 8'h42;
	localparam logic [7:0] MODE2_WR_MASK = 8'h27;
	localparam logic [7:0] MODE2_RESET = 8'hD8;
	localparam logic [7:0] DIR_READ_VAL = 8'hFF;
	localparam logic [7:0] PORT_RESET = 8'h00;
	localparam int BIT_P7 = 7;
	localparam int BIT_P4 = 4;
	localparam int BIT_P3 = 3;
	localparam int BIT_WDOG_CLK = 2;
	localparam int BIT_FILT_ON = 1;
	localparam int BIT_EDGE_RISE = 0;
	localparam int FILT_LEN_DEF = 3;

	// ----------------------------------------------------------------
	// bus answers and register selector codes
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		POGPM_SEL_NONE = 3'h0,
		POGPM_SEL_FUNC = 3'h1,
		POGPM_SEL_MODE2 = 3'h2,
		POGPM_SEL_DATA = 3'h3,
		POGPM_SEL_PULL = 3'h4,
		POGPM_SEL_DIR = 3'h5,
		POGPM_SEL_EDGE = 3'h6
	} pogpm_sel_t;

	// write channel: gray along idle -> one half -> response
	typedef enum logic [1:0] {
		POGPM_W_IDLE = 2'h0,
		POGPM_W_ADDR = 2'h1,
		POGPM_W_RESP = 2'h3,
		POGPM_W_DATA = 2'h2
	} pogpm_wr_state_t;

endpackage

// ### rtl/pogpm_edge_detect.sv
/*
 * Edge detector for the pin 7 interrupt / timer event input.
 * Assumes the input is already synchronous to clk; idle level is high.
 */
module pogpm_edge_detect (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sig_in,
	input wire logic rise_sel,
	output logic event_pulse
);

	logic prev_r;

	// ----------------------------------------------------------------
	// edge capture
	// ----------------------------------------------------------------
	// previous level resets high so a high line at release is no edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_r <= 1'b1;
			event_pulse <= 1'b0;
		end else begin
			prev_r <= sig_in;
			event_pulse <= rise_sel ? (sig_in & ~prev_r)
				: (~sig_in & prev_r);
		end
	end

endmodule

// ### rtl/pogpm_noise_filter.sv
/*
 * Noise filter for the capture input: the output follows the input
 * only after FILT_LEN equal samples in a row.
 * Assumes the input is synchronous to clk; idle level is high.
 */
module pogpm_noise_filter #(
	parameter int FILT_LEN = 3
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sig_in,
	output logic filt_out
);

	logic [FILT_LEN-1:0] hist_r;

	// ----------------------------------------------------------------
	// sample history and decision
	// ----------------------------------------------------------------
	// a glitch shorter than FILT_LEN cycles never reaches the output
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hist_r <= '1;
			filt_out <= 1'b1;
		end else begin
			hist_r <= {hist_r[FILT_LEN-2:0], sig_in};
			if (&hist_r)
				filt_out <= 1'b1;
			else if (~|hist_r)
				filt_out <= 1'b0;
		end
	end

endmodule

// ### tb/pogpm_pin_model.sv
/*
 * Behavioural model of the package pins around the four-pin port.
 * Assumes the bench gives each pin an external level and an enable;
 * the port's own drive wins, and an undriven pin without pull-up
 * shows a level that flips every clock.
 */
module pogpm_pin_model (
	input wire logic clk,
	input wire logic [7:0] ext_val,
	input wire logic [7:0] ext_en,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] pin_pullup_en,
	output logic [7:0] pin_in
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] float_r;

	// floating pins flip so a stale value never passes for a real one;
	// the first edge turns the unknown start into a defined pattern
	always_ff @(posedge clk) begin
		float_r <= (float_r === 8'h55) ? 8'hAA : 8'h55;
	end

	// port drive first, then external drive, then pull-up, else float
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
		| (~pin_oe & ~ext_en & pin_pullup_en)
		| (~pin_oe & ~ext_en & ~pin_pullup_en & float_r);
endmodule

// ### tb/pogpm_port_sva.sv
/*
 * Checker for the four-pin port: pin drive, pull-up, alternate inputs
 * and register bus answers.
 * Assumes it is bound into pogpm_port and sees only its ports.
 */
module pogpm_port_sva #(
	parameter int FILT_LEN = 3
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] pin_pullup_en,
	input wire logic ext_int_three_level,
	input wire logic pin7_edge_event,
	input wire logic ext_int_four_level,
	input wire logic converter_trigger_level,
	input wire logic capture_input_level,
	input wire logic watchdog_clock_select
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	logic [7:0] cap_cnt_r;

	// cycles pin 3 has been a driven output; saturates
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cap_cnt_r <= 8'h00;
		end else if (!pin_oe[3]) begin
			cap_cnt_r <= 8'h00;
		end else if (cap_cnt_r != 8'hFF) begin
			cap_cnt_r <= cap_cnt_r + 8'h01;
		end
	end

	a_reset_quiet: assert property (
		$rose(rst_n) |-> pin_oe == 8'h00 && pin_pullup_en == 8'h00
			&& !watchdog_clock_select)
		else $error("pins or watchdog select active after reset");
	a_no_pull_drive: assert property (
		(pin_pullup_en & pin_oe) == 8'h00)
		else $error("pull-up on a driven pin");
	a_mapped_only: assert property (
		((pin_oe | pin_pullup_en) & 8'h27) == 8'h00)
		else $error("unmapped bit drives or pulls up");
	a_eint3_idle: assert property (
		pin_oe[7] && $past(pin_oe[7]) |-> ext_int_three_level)
		else $error("pin 7 output yet interrupt level low");
	a_eint4_idle: assert property (
		pin_oe[4] && $past(pin_oe[4]) |-> ext_int_four_level
			&& converter_trigger_level)
		else $error("pin 4 output yet trigger level low");
	a_capture_idle: assert property (
		cap_cnt_r > FILT_LEN + 3 |-> capture_input_level)
		else $error("pin 3 output yet capture level low");
	a_event_single: assert property (
		pin7_edge_event |=> !pin7_edge_event)
		else $error("edge event longer than one cycle");
	a_event_gpio: assert property (
		pin_oe[7] [*3] |=> !pin7_edge_event)
		else $error("edge event while pin 7 is general I/O");
	a_wr_answer: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|-> ##2 s_axi_bvalid)
		else $error("write answer late");
	a_b_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
			&& $stable(s_axi_bresp))
		else $error("write answer dropped before taken");
	a_rd_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	a_rdata_byte: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("read data above low byte");

	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
	c_event: cover property (pin7_edge_event);
endmodule

bind pogpm_port pogpm_port_sva #(.FILT_LEN(FILT_LEN)) u_sva (
	.clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready, .pin_oe, .pin_pullup_en, .ext_int_three_level,
	.pin7_edge_event, .ext_int_four_level, .converter_trigger_level,
	.capture_input_level, .watchdog_clock_select
);

// ### tb/test_pogpm_port.sv
/*
 * Self-checking bench for the four-pin port: register access over the
 * register bus, pin drive, pull-ups, alternate inputs, edge and filter.
 * Assumes the pin model and the bound checker are compiled with it.
 */
module test_pogpm_port;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [17:0] awaddr = 18'h00000, araddr = 18'h00000;
	logic [31:0] wdata = 32'h00000000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [7:0] pin_in, pin_out, pin_oe, pull_en, rd, dv;
	logic [7:0] ext_val = 8'h4B, ext_en = 8'hFF;
	logic eint3, ev7, eint4, trig, cap, wdog, low;
	int fail_count = 0, n_compared = 0, c;

	pogpm_port dut (
		.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_pullup_en(pull_en),
		.ext_int_three_level(eint3),
		.pin7_edge_event(ev7), .ext_int_four_level(eint4),
		.converter_trigger_level(trig), .capture_input_level(cap),
		.watchdog_clock_select(wdog)
	);

	pogpm_pin_model pins (
		.clk(clk), .ext_val(ext_val), .ext_en(ext_en), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_pullup_en(pull_en), .pin_in(pin_in)
	);

	// free-running 250 MHz clock
	initial begin
		forever #2 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	// bready stands from the request until the answer is sampled
	task automatic wr(input logic [17:0] a, input logic [7:0] d,
		input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge clk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				chk(bresp, er);
				bready <= 1'b0;
				break;
			end
			if (n > 40) begin
				fail_count++;
				break;
			end
		end
	endtask

	task automatic rd_reg(input logic [17:0] a, output logic [7:0] d,
		input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) begin
				chk(rresp, er);
				d = rdata[7:0];
				rready <= 1'b0;
				break;
			end
			if (n > 40) begin
				fail_count++;
				break;
			end
		end
	endtask

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// move pin 7 and count edge events in the following cycles
	task automatic pin7_step(input logic v, output int cnt);
		@(posedge clk);
		ext_val[7] <= v;
		cnt = 0;
		repeat (6) begin
			@(posedge clk);
			#1;
			if (ev7 === 1'b1) cnt++;
		end
	endtask

	task automatic finish_test();
		if (fail_count == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// test sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rd_reg(pogpm_pkg::ADDR_FUNC_SEL, rd, 2'h0);
		chk(rd, 8'h42);
		rd_reg(pogpm_pkg::ADDR_MODE_TWO, rd, 2'h0);
		chk(rd, 8'hD8);
		rd_reg(pogpm_pkg::ADDR_PULLUP, rd, 2'h0);
		chk(rd & 8'hD8, 8'h00);
		rd_reg(pogpm_pkg::ADDR_OUT_DATA, rd, 2'h0);
		chk(rd & 8'hD8, ext_val & 8'hD8);
		chk({pin_oe, pull_en, wdog}, 17'h00000);
		// per-bit direction with data opposite to the pins
		for (int i = 0; i < 3; i++) begin
			dv = (i == 0) ? 8'h90 : (i == 1) ? 8'h48 : 8'hFF;
			wr(pogpm_pkg::ADDR_DIR, dv, 2'h0);
			wr(pogpm_pkg::ADDR_OUT_DATA, 8'h95, 2'h0);
			wait_clk(2);
			chk(pin_oe, dv & 8'hD8);
			chk(pin_out, 8'h95 & dv & 8'hD8);
			rd_reg(pogpm_pkg::ADDR_OUT_DATA, rd, 2'h0);
			chk(rd & 8'hD8, ((8'h95 & dv) | (ext_val & ~dv)) & 8'hD8);
			rd_reg(pogpm_pkg::ADDR_DIR, rd, 2'h0);
			chk(rd, 8'hFF);
		end
		wr(pogpm_pkg::ADDR_DIR, 8'h90, 2'h0);
		wr(pogpm_pkg::ADDR_PULLUP, 8'hFF, 2'h0);
		ext_en <= 8'hBF;
		wait_clk(2);
		chk(pull_en, 8'h48);
		rd_reg(pogpm_pkg::ADDR_OUT_DATA, rd, 2'h0);
		chk(rd[6], 1'b1);
		rd_reg(pogpm_pkg::ADDR_PULLUP, rd, 2'h0);
		chk(rd & 8'hD8, 8'hD8);
		ext_en <= 8'hFF;
		wr(pogpm_pkg::ADDR_DIR, 8'hD8, 2'h0);
		wr(pogpm_pkg::ADDR_FUNC_SEL, 8'h98, 2'h0);
		for (int i = 0; i < 2; i++) begin
			ext_val <= (i == 0) ? 8'h4B : 8'hB4;
			wait_clk(3);
			chk(pin_oe, 8'h40);
			chk(pull_en, 8'h98);
			chk({eint3, eint4, trig, cap},
				{ext_val[7], ext_val[4], ext_val[4], ext_val[3]});
			rd_reg(pogpm_pkg::ADDR_OUT_DATA, rd, 2'h0);
			chk(rd & 8'hD8, 8'h95 & 8'hD8);
		end
		rd_reg(pogpm_pkg::ADDR_FUNC_SEL, rd, 2'h0);
		chk(rd, 8'hDA);
		wr(pogpm_pkg::ADDR_MODE_TWO, 8'h04, 2'h0);
		wait_clk(2);
		chk(wdog, 1'b1);
		rd_reg(pogpm_pkg::ADDR_MODE_TWO, rd, 2'h0);
		chk(rd, 8'hDC);
		// one-cycle glitch on the capture pin, filter off then on
		for (int i = 0; i < 2; i++) begin
			wr(pogpm_pkg::ADDR_MODE_TWO, {6'h00, i[0], 1'b0}, 2'h0);
			ext_val[3] <= 1'b1;
			wait_clk(8);
			@(posedge clk);
			ext_val[3] <= 1'b0;
			@(posedge clk);
			ext_val[3] <= 1'b1;
			low = 1'b0;
			repeat (10) begin
				#1;
				low = low | !cap;
				@(posedge clk);
			end
			chk(low, !i[0]);
		end
		for (int i = 0; i < 2; i++) begin
			wr(pogpm_pkg::ADDR_EDGE_CTRL, {7'h00, i[0]}, 2'h0);
			pin7_step(1'b0, c);
			pin7_step(1'b1, c);
			chk(c, i);
			pin7_step(1'b0, c);
			chk(c, 1 - i);
		end
		wr(18'h00000, 8'hFF, 2'h2);
		rd_reg(18'h00000, rd, 2'h2);
		chk(rd, 8'h00);
		finish_test();
	end

	// hang guard, far beyond the few hundred cycles the tests take
	initial begin
		#40000;
		fail_count++;
		finish_test();
	end
endmodule
